/* hdl/moc_pkg.sv */
/*
 * Shared constants and carrier types for the measurement offset correction block.
 * Assumes one 100 MHz clock domain; command and raw-result sources run on it.
 */
// What this block does
// - after reset both offset magnitudes and both signs are zero, so results pass uncorrected.
// - the humidity magnitude is seven weighted bits landing on result bits 13..7; sign 1 adds.
// - the humidity offset spans one step up to 24.8046875 %RH with all seven bits set.
// - a subtracted humidity offset that would go below zero reports zero instead.
// - the temperature magnitude is seven weighted bits on result bits 12..6; sign 1 adds.
// - the temperature offset reaches at most 21.7041015625 degC with all seven bits set.
// - corrected humidity depends only on the raw humidity and humidity offset fields.
// - the verify command returns the offset word currently held.
// - word bit 15 is the humidity sign and bit 7 the temperature sign.
// - a write whose CRC byte does not match is refused with a not-acknowledge.
package moc_pkg;

    localparam logic [15:0] OFS_RESET = 16'h0000;
    localparam int HUM_SIGN_BIT = 15;
    localparam int HUM_MAG_MSB = 14;
    localparam int HUM_MAG_LSB = 8;
    localparam int TMP_SIGN_BIT = 7;
    localparam int TMP_MAG_MSB = 6;
    localparam int TMP_MAG_LSB = 0;
    localparam int HUM_SHIFT = 7;
    localparam int TMP_SHIFT = 6;
    localparam logic [15:0] HUM_MAX_DELTA = 16'h3f80;
    localparam logic [15:0] TMP_MAX_DELTA = 16'h1fc0;
    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'hff;

    typedef struct packed {
        logic wr_valid;
        logic rd_valid;
        logic [15:0] word;
        logic [7:0] crc;
    } moc_cmd_t;

    typedef struct packed {
        logic valid;
        logic [15:0] hum;
        logic [15:0] temp;
    } moc_raw_t;

    typedef struct packed {
        logic [15:0] ofs_word;
        logic wr_ack;
        logic wr_nack;
        logic rd_valid;
        logic [15:0] rd_word;
        logic [7:0] rd_crc;
        logic res_valid;
        logic [15:0] hum;
        logic [15:0] temp;
    } moc_state_t;

endpackage

/* hdl/moc_crc8.sv */
/*
 * Combinational CRC-8 over a 16-bit word, most significant byte first.
 * Assumes the polynomial and start value are given by the instantiating module.
 */
`timescale 1ns/1ns
module moc_crc8 #(
    parameter logic [7:0] POLY = 8'h31,
    parameter logic [7:0] INIT = 8'hff
) (
    input wire logic [15:0] data,
    output logic [7:0] crc
);
    always_comb
    begin
        logic [7:0] c;
        c = INIT;
        for (int i = 15; i >= 0; i--)
        begin
            if (c[7] ^ data[i])
            begin
                c = {c[6:0], 1'b0} ^ POLY;
            end
            else
            begin
                c = {c[6:0], 1'b0};
            end
        end
        crc = c;
    end
endmodule

/* hdl/moc_offset_top.sv */
/*
 * Offset word store, CRC-checked write, read-back, and correction of
 * humidity and temperature result codes.
 * Assumes command and raw-result strobes come from logic on ref_clk; the
 * serial bus front end and the measurement core sit outside.
 */
`timescale 1ns/1ns
module moc_offset_top
    import moc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire moc_cmd_t cmd,
    input wire moc_raw_t raw,
    output logic wr_ack,
    output logic wr_nack,
    output logic rd_valid,
    output logic [15:0] rd_word,
    output logic [7:0] rd_crc,
    output logic res_valid,
    output logic [15:0] hum_out,
    output logic [15:0] temp_out
);
    moc_state_t s_q;
    moc_state_t s_d;
    logic [7:0] wr_crc_calc;
    logic [7:0] rd_crc_calc;
    logic crc_ok;
    logic [15:0] hum_delta;
    logic [15:0] tmp_delta;

    // saturating add or floor-at-zero subtract of an offset on a result code
    function automatic logic [15:0] apply_ofs(input logic [15:0] r, input logic [15:0] dl,
                                              input logic add);
        logic [16:0] sum;
        sum = {1'b0, r} + {1'b0, dl};
        if (add)
        begin
            apply_ofs = sum[16] ? 16'hffff : sum[15:0];
        end
        else
        begin
            apply_ofs = (r < dl) ? 16'h0000 : r - dl;
        end
    endfunction

    moc_crc8 #(.POLY(CRC_POLY), .INIT(CRC_INIT)) u_wr_crc (
        .data(cmd.word),
        .crc(wr_crc_calc)
    );

    moc_crc8 #(.POLY(CRC_POLY), .INIT(CRC_INIT)) u_rd_crc (
        .data(s_q.ofs_word),
        .crc(rd_crc_calc)
    );

    assign crc_ok = (wr_crc_calc == cmd.crc);
    // magnitude fields land on the result code bit weights
    assign hum_delta = 16'(s_q.ofs_word[HUM_MAG_MSB:HUM_MAG_LSB])
        << HUM_SHIFT;
    assign tmp_delta = 16'(s_q.ofs_word[TMP_MAG_MSB:TMP_MAG_LSB])
        << TMP_SHIFT;

    always_comb
    begin
        s_d = s_q;
        s_d.wr_ack = 1'b0;
        s_d.wr_nack = 1'b0;
        s_d.rd_valid = 1'b0;
        s_d.res_valid = raw.valid;
        if (cmd.wr_valid)
        begin
            if (crc_ok)
            begin
                s_d.ofs_word = cmd.word;
                s_d.wr_ack = 1'b1;
            end
            else
            begin
                s_d.wr_nack = 1'b1;
            end
        end
        // a read in the same cycle as a write returns the old word
        if (cmd.rd_valid)
        begin
            s_d.rd_valid = 1'b1;
            s_d.rd_word = s_q.ofs_word;
            s_d.rd_crc = rd_crc_calc;
        end
        if (raw.valid)
        begin
            // humidity never sees the temperature offset fields
            s_d.hum = apply_ofs(raw.hum, hum_delta, s_q.ofs_word[HUM_SIGN_BIT]);
            s_d.temp = apply_ofs(raw.temp, tmp_delta, s_q.ofs_word[TMP_SIGN_BIT]);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_q <= '0;
            s_q.ofs_word <= OFS_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign wr_ack = s_q.wr_ack;
    assign wr_nack = s_q.wr_nack;
    assign rd_valid = s_q.rd_valid;
    assign rd_word = s_q.rd_word;
    assign rd_crc = s_q.rd_crc;
    assign res_valid = s_q.res_valid;
    assign hum_out = s_q.hum;
    assign temp_out = s_q.temp;

    // helper: set once any write has been accepted
    logic seen_wr_q;
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            seen_wr_q <= 1'b0;
        end
        else if (s_q.wr_ack)
        begin
            seen_wr_q <= 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    zero_default_a: assert property (
        !seen_wr_q && !s_q.wr_ack |-> s_q.ofs_word == 16'h0000)
        else $error("offset word nonzero before any accepted write");

    hum_add_a: assert property (
        raw.valid && s_q.ofs_word[15] && ({1'b0, raw.hum} + {1'b0, hum_delta} < 17'h10000)
        |=> hum_out == $past(raw.hum) + $past(hum_delta))
        else $error("humidity add offset wrong");

    hum_max_a: assert property (
        raw.valid && raw.hum == 16'h0000 && s_q.ofs_word[15:8] == 8'hff
        |=> res_valid && hum_out == HUM_MAX_DELTA)
        else $error("humidity full-scale offset wrong");

    hum_clamp_a: assert property (
        raw.valid && !s_q.ofs_word[15] && raw.hum < hum_delta |=> hum_out == 16'h0000)
        else $error("humidity not clamped at zero");

    tmp_sub_a: assert property (
        raw.valid && !s_q.ofs_word[7] && raw.temp >= tmp_delta
        |=> temp_out == $past(raw.temp) - $past(tmp_delta))
        else $error("temperature subtract offset wrong");

    tmp_max_a: assert property (
        raw.valid && raw.temp == 16'h0000 && s_q.ofs_word[7:0] == 8'hff
        |=> temp_out == TMP_MAX_DELTA)
        else $error("temperature full-scale offset wrong");

    hum_indep_a: assert property (
        raw.valid && $past(raw.valid) && raw.hum == $past(raw.hum)
        && s_q.ofs_word[15:8] == $past(s_q.ofs_word[15:8])
        |=> hum_out == $past(hum_out))
        else $error("humidity moved with temperature offset");

    // back-to-back reads are legal, so the pulse end is checked per cycle below
    readback_a: assert property (
        cmd.rd_valid |=> rd_valid && rd_word == $past(s_q.ofs_word))
        else $error("read-back word wrong");

    rd_pulse_a: assert property (
        !cmd.rd_valid |=> !rd_valid && rd_word == $past(rd_word))
        else $error("read-back output moved without a read");

    rd_crc_a: assert property (
        cmd.rd_valid |=> rd_crc == $past(rd_crc_calc))
        else $error("read-back crc wrong");

    bad_crc_a: assert property (
        cmd.wr_valid && !crc_ok |=> wr_nack && !wr_ack && s_q.ofs_word == $past(s_q.ofs_word))
        else $error("bad crc write accepted");

    good_write_a: assert property (
        cmd.wr_valid && crc_ok |=> wr_ack && !wr_nack && s_q.ofs_word == $past(cmd.word))
        else $error("good write not stored");

    word_hold_a: assert property (
        !cmd.wr_valid |=> !wr_ack && !wr_nack && s_q.ofs_word == $past(s_q.ofs_word))
        else $error("offset word moved without a write");

    ack_excl_a: assert property (
        !(wr_ack && wr_nack))
        else $error("write acknowledged and refused together");

    // codes are unsigned: subtract floors at zero, add saturates at full scale
    hum_sub_a: assert property (
        raw.valid && !s_q.ofs_word[HUM_SIGN_BIT] && raw.hum >= hum_delta
        |=> hum_out == $past(raw.hum) - $past(hum_delta))
        else $error("humidity subtract offset wrong");

    hum_sat_a: assert property (
        raw.valid && s_q.ofs_word[HUM_SIGN_BIT]
        && ({1'b0, raw.hum} + {1'b0, hum_delta} >= 17'h10000)
        |=> hum_out == 16'hffff)
        else $error("humidity add did not saturate");

    tmp_add_a: assert property (
        raw.valid && s_q.ofs_word[TMP_SIGN_BIT]
        && ({1'b0, raw.temp} + {1'b0, tmp_delta} < 17'h10000)
        |=> temp_out == $past(raw.temp) + $past(tmp_delta))
        else $error("temperature add offset wrong");

    tmp_clamp_a: assert property (
        raw.valid && !s_q.ofs_word[TMP_SIGN_BIT] && raw.temp < tmp_delta
        |=> temp_out == 16'h0000)
        else $error("temperature not floored at zero");

    tmp_sat_a: assert property (
        raw.valid && s_q.ofs_word[TMP_SIGN_BIT]
        && ({1'b0, raw.temp} + {1'b0, tmp_delta} >= 17'h10000)
        |=> temp_out == 16'hffff)
        else $error("temperature add did not saturate");

    res_strobe_a: assert property (
        raw.valid |=> res_valid)
        else $error("result strobe missing");

    // results hold between strobes so a slow reader sees a stable pair
    res_hold_a: assert property (
        !raw.valid |=> !res_valid && hum_out == $past(hum_out)
        && temp_out == $past(temp_out))
        else $error("results moved without a raw strobe");

endmodule

/* verif/moc_host_model.sv */
/*
 * Host side of the offset command port: writes with CRC, reads back.
 * Assumes the design samples cmd on the rising edge of ref_clk.
 */
`timescale 1ns/1ns
module moc_host_model
    import moc_pkg::*;
#(
    parameter int SETTLE_GAP = 6
)
(
    input wire logic ref_clk,
    input wire logic wr_ack,
    input wire logic wr_nack,
    input wire logic rd_valid,
    input wire logic [15:0] rd_word,
    output moc_cmd_t cmd
);
    initial cmd = '0;

    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--)
            c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
        return c;
    endfunction

    // word and crc travel in one cycle; bad flips one crc bit
    task automatic write(input logic [15:0] w, input logic bad, output logic a, output logic n);
        @(posedge ref_clk);
        #1 cmd = {1'b1, 1'b0, w, crc8(w) ^ {7'h00, bad}};
        @(posedge ref_clk);
        #1 a = wr_ack;
        n = wr_nack;
        cmd = {2'b00, ~w, 8'h00};
        // busy windows scaled down: the design enforces none
        repeat (SETTLE_GAP) @(posedge ref_clk);
    endtask

    task automatic read(output logic [15:0] w);
        @(posedge ref_clk);
        #1 cmd.rd_valid = 1'b1;
        @(posedge ref_clk);
        #1 w = (rd_valid === 1'b1) ? rd_word : 16'bx;
        cmd.rd_valid = 1'b0;
    endtask
endmodule

/* verif/tb.sv */
/*
 * Self-checking bench for the offset correction block.
 * Assumes the host model drives cmd; raw results come from here.
 */
`timescale 1ns/1ns
module tb;
    import moc_pkg::*;
    logic ref_clk;
    logic reset_n;
    moc_cmd_t cmd;
    moc_raw_t raw;
    logic wr_ack, wr_nack, rd_valid, res_valid;
    logic [15:0] rd_word, hum_out, temp_out, w;
    logic [7:0] rd_crc;
    logic a, n;
    int n_errors = 0;
    int n_checks = 0;
    logic [15:0] words [5] = '{16'haa2a, 16'hff7f, 16'h7fff, 16'h0181, 16'h8000};
    logic [31:0] raws [4] = '{32'h1000_8000, 32'h0050_0040, 32'hff00_ffe0, 32'h0000_0000};

    moc_offset_top uut (.ref_clk(ref_clk), .reset_n(reset_n), .cmd(cmd), .raw(raw),
        .wr_ack(wr_ack), .wr_nack(wr_nack), .rd_valid(rd_valid), .rd_word(rd_word),
        .rd_crc(rd_crc), .res_valid(res_valid), .hum_out(hum_out), .temp_out(temp_out));
    moc_host_model host (.ref_clk(ref_clk), .wr_ack(wr_ack), .wr_nack(wr_nack),
        .rd_valid(rd_valid), .rd_word(rd_word), .cmd(cmd));

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic final_report;
        if (n_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // codes are unsigned: subtract floors at zero, add saturates
    function automatic logic [15:0] corr(input logic [15:0] code, input logic [6:0] mag,
            input logic add, input int sh);
        logic [16:0] d;
        d = {10'h000, mag} << sh;
        if (add)
            return ({1'b0, code} + d > 17'h0ffff) ? 16'hffff : code + d[15:0];
        return (d > {1'b0, code}) ? 16'h0000 : code - d[15:0];
    endfunction

    task automatic run_raws(input logic [15:0] ow);
        for (int j = 0; j < 4; j++)
        begin
            @(posedge ref_clk);
            #1 raw = {1'b1, raws[j]};
            @(posedge ref_clk);
            #1 raw.valid = 1'b0;
            chk("res_valid", 16'h0001, {15'h0000, res_valid});
            chk("hum_out", corr(raws[j][31:16], ow[14:8], ow[15], 7), hum_out);
            chk("temp_out", corr(raws[j][15:0], ow[6:0], ow[7], 6), temp_out);
        end
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        final_report;
    end

    initial
    begin
        reset_n = 1'b0;
        raw = '0;
        repeat (16) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        host.read(w);
        chk("rd_word", 16'h0000, w);
        chk("rd_crc", {8'h00, host.crc8(16'h0000)}, {8'h00, rd_crc});
        run_raws(16'h0000);
        foreach (words[i])
        begin
            host.write(words[i], 1'b0, a, n);
            chk("wr_ack", 16'h0001, {14'h0000, n, a});
            host.read(w);
            chk("rd_word", words[i], w);
            chk("rd_crc", {8'h00, host.crc8(words[i])}, {8'h00, rd_crc});
            run_raws(words[i]);
        end
        host.write(16'h1234, 1'b1, a, n);
        chk("wr_nack", 16'h0002, {14'h0000, n, a});
        host.read(w);
        chk("rd_word", words[4], w);
        // only the temperature half changes; measurements stay off during the write
        host.write({words[4][15:8], 8'hff}, 1'b0, a, n);
        chk("wr_ack", 16'h0001, {14'h0000, n, a});
        @(posedge ref_clk);
        #1 raw = {1'b1, raws[0]};
        repeat (2) @(posedge ref_clk);
        #1 raw.valid = 1'b0;
        chk("res_valid", 16'h0001, {15'h0000, res_valid});
        chk("hum_out", corr(raws[0][31:16], words[4][14:8], words[4][15], 7), hum_out);
        chk("temp_out", corr(raws[0][15:0], 7'h7f, 1'b1, 6), temp_out);
        final_report;
    end
endmodule
